// *** verilog/iwa_control.v ***
// Two-wire bus interrupt, wait, address match and arbitration control
`timescale 1ns/10ps
`default_nettype none
`include "iwa_map.vh"
module iwa_control (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Bus pins, open drain, enable high drives low
  input wire sclIn,
  output wire sclOut,
  output wire sclOe,
  input wire sdaIn,
  output wire sdaOut,
  output wire sdaOe,
  // Control bits
  input wire waitTimingSelect,
  input wire acknowledgeEnable,
  input wire stopInterruptEnable,
  input wire [7:0] localSlaveAddress,
  input wire waitRelease,
  input wire startRequest,
  input wire stopRequest,
  input wire leaveCommunication,
  input wire arbLostClear,
  input wire shiftWrite,
  input wire [7:0] shiftWriteData,
  // Status
  output reg [7:0] shiftData_q,
  output wire [7:0] busStatusRegister,
  output reg [2:0] extensionKind_q,
  output reg busInterrupt_q,
  output reg waitActive_q
);
  localparam S_IDLE = 3'h0;
  localparam S_ADDR = 3'h1;
  localparam S_DATA = 3'h2;
  localparam S_DROP = 3'h3;
  localparam S_START = 3'h4;
  localparam S_STOP = 3'h5;

  reg [2:0] state_q;
  reg [3:0] bitCnt_q;
  reg sclPrev_q;
  reg sdaPrev_q;
  reg master_q;
  reg transmit_q;
  reg extCode_q;
  reg addrMatch_q;
  reg arbLost_q;
  reg ackSeen_q;
  reg startSeen_q;
  reg stopSeen_q;
  reg driveSda_q;
  reg driveScl_q;
  wire [1:0] lineSync;
  wire sclS;
  wire sdaS;
  wire sclFall;
  wire sclRise;
  wire startCond;
  wire stopCond;
  wire releaseEvent;
  wire sendBit;

  iwa_sync #(.WIDTH(2)) uSync (
    .clk(clk),
    .rst_n(rst_n),
    .asyncIn({sclIn, sdaIn}),
    .syncOut(lineSync)
  );
  assign sclS = lineSync[1];
  assign sdaS = lineSync[0];
  assign sclFall = sclPrev_q & ~sclS;
  assign sclRise = ~sclPrev_q & sclS;
  assign startCond = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
  assign stopCond = sclS & sclPrev_q & ~sdaPrev_q & sdaS;
  assign releaseEvent = waitRelease | shiftWrite | startRequest | stopRequest;

  // Extension code classification
  function [2:0] classifyExt;
    input [7:0] a;
    begin
      if (a[7:1] == 7'h00) begin
        classifyExt = a[0] ? `IWA_EXT_STARTBYTE : `IWA_EXT_GENCALL;
      end else if (a[7:1] == 7'h01) begin
        classifyExt = `IWA_EXT_CBUS;
      end else if (a[7:1] == 7'h02) begin
        classifyExt = `IWA_EXT_RESERVED;
      end else if (a[7:3] == 5'h1e) begin
        classifyExt = `IWA_EXT_TENBIT;
      end else begin
        classifyExt = `IWA_EXT_NONE;
      end
    end
  endfunction

  // Upper four bits all zero or all one
  function isExt;
    input [3:0] hi;
    begin
      isExt = (hi == 4'h0) | (hi == 4'hf);
    end
  endfunction

  assign sendBit = transmit_q | (master_q & state_q == S_ADDR);
  assign busStatusRegister = {master_q, arbLost_q, extCode_q, addrMatch_q,
                              transmit_q, ackSeen_q, startSeen_q, stopSeen_q};
  assign sdaOut = 1'b0;
  assign sdaOe = driveSda_q & ~arbLost_q;
  assign sclOut = 1'b0;
  assign sclOe = (waitActive_q | driveScl_q) & ~arbLost_q;

  always @(posedge clk) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      bitCnt_q <= 4'h0;
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
      master_q <= 1'b0;
      transmit_q <= 1'b0;
      extCode_q <= 1'b0;
      addrMatch_q <= 1'b0;
      arbLost_q <= 1'b0;
      ackSeen_q <= 1'b0;
      startSeen_q <= 1'b0;
      stopSeen_q <= 1'b0;
      driveSda_q <= 1'b0;
      driveScl_q <= 1'b0;
      shiftData_q <= `IWA_RESET_STATUS;
      extensionKind_q <= `IWA_EXT_NONE;
      busInterrupt_q <= 1'b0;
      waitActive_q <= 1'b0;
    end else begin
      sclPrev_q <= sclS;
      sdaPrev_q <= sdaS;
      busInterrupt_q <= 1'b0;
      if (waitActive_q && releaseEvent) begin
        waitActive_q <= 1'b0;
      end
      if (shiftWrite) begin
        shiftData_q <= shiftWriteData;
      end
      if (arbLostClear) begin
        arbLost_q <= 1'b0;
      end
      if (stopCond) begin
        stopSeen_q <= 1'b1;
        startSeen_q <= 1'b0;
        master_q <= 1'b0;
        transmit_q <= 1'b0;
        extCode_q <= 1'b0;
        addrMatch_q <= 1'b0;
        driveSda_q <= 1'b0;
        driveScl_q <= 1'b0;
        waitActive_q <= 1'b0;
        state_q <= S_IDLE;
        if (state_q != S_STOP && master_q) begin
          arbLost_q <= 1'b1;
        end
        busInterrupt_q <= stopInterruptEnable;
      end else if (startCond) begin
        startSeen_q <= 1'b1;
        stopSeen_q <= 1'b0;
        extCode_q <= 1'b0;
        addrMatch_q <= 1'b0;
        transmit_q <= 1'b0;
        // Wraps to zero on the start's own clock fall
        bitCnt_q <= `IWA_CNT_PRESTART;
        state_q <= S_ADDR;
        if (!(state_q == S_START || master_q)) begin
          master_q <= 1'b0;
        end
        if (state_q == S_START) begin
          master_q <= 1'b1;
          driveSda_q <= 1'b1;
        end
      end else if (leaveCommunication) begin
        state_q <= S_DROP;
        extCode_q <= 1'b0;
        addrMatch_q <= 1'b0;
        transmit_q <= 1'b0;
        driveSda_q <= 1'b0;
        waitActive_q <= 1'b0;
      end else begin
        if (state_q == S_IDLE && startRequest && !startSeen_q) begin
          state_q <= S_START;
          driveSda_q <= 1'b1;
        end
        if (stopRequest && master_q) begin
          state_q <= S_STOP;
          driveSda_q <= 1'b1;
        end
        if (state_q == S_STOP && sclS && driveSda_q) begin
          driveSda_q <= 1'b0;
        end
        if (shiftWrite && (master_q || transmit_q)) begin
          driveSda_q <= ~shiftWriteData[7];
        end
        // First bit of a data byte rises while the count still shows nine
        if (sclRise && (state_q == S_ADDR || state_q == S_DATA) &&
            (bitCnt_q < `IWA_CLK8 || bitCnt_q == `IWA_CLK9)) begin
          shiftData_q <= {shiftData_q[6:0], sdaS};
          if (sendBit && driveSda_q == 1'b0 && !sdaS) begin
            arbLost_q <= 1'b1;
            master_q <= 1'b0;
            transmit_q <= 1'b0;
            driveSda_q <= 1'b0;
          end
        end
        if (sclRise && state_q == S_STOP && !sdaS && bitCnt_q == 4'h0) begin
          arbLost_q <= 1'b1;
        end
        if (sclFall && (state_q == S_ADDR || state_q == S_DATA)) begin
          bitCnt_q <= (bitCnt_q == `IWA_CLK9) ? 4'h1 : bitCnt_q + 4'h1;
          if (sendBit && (bitCnt_q < 4'h7 || bitCnt_q == `IWA_CLK9)) begin
            driveSda_q <= ~shiftData_q[7];
          end else if (bitCnt_q == 4'h7) begin
            driveSda_q <= 1'b0;
            if (state_q == S_ADDR) begin
              extensionKind_q <= classifyExt(shiftData_q);
              if (isExt(shiftData_q[7:4]) && !master_q) begin
                extCode_q <= 1'b1;
                busInterrupt_q <= 1'b1;
                waitActive_q <= ~waitTimingSelect;
                driveSda_q <= 1'b1;
              end
              if (!master_q && shiftData_q[7:1] == localSlaveAddress[7:1]) begin
                addrMatch_q <= 1'b1;
                transmit_q <= shiftData_q[0];
                driveSda_q <= 1'b1;
              end
            end else if (!waitTimingSelect && (master_q || addrMatch_q || extCode_q)) begin
              busInterrupt_q <= 1'b1;
              waitActive_q <= 1'b1;
              if (!transmit_q) begin
                driveSda_q <= acknowledgeEnable;
              end
            end else if (!waitTimingSelect && arbLost_q && extCode_q) begin
              busInterrupt_q <= 1'b1;
            end else if (!transmit_q && (master_q || addrMatch_q || extCode_q)) begin
              driveSda_q <= acknowledgeEnable;
            end
          end else if (bitCnt_q == 4'h8) begin
            ackSeen_q <= ~sdaS;
            driveSda_q <= 1'b0;
            if (state_q == S_ADDR) begin
              state_q <= S_DATA;
              if (master_q) begin
                busInterrupt_q <= 1'b1;
                waitActive_q <= 1'b1;
                transmit_q <= ~shiftData_q[0];
              end else if (addrMatch_q && !extCode_q) begin
                busInterrupt_q <= 1'b1;
                waitActive_q <= 1'b1;
              end else if (extCode_q && waitTimingSelect) begin
                waitActive_q <= 1'b1;
              end else if (!extCode_q && arbLost_q && waitTimingSelect) begin
                busInterrupt_q <= 1'b1;
              end else if (!extCode_q) begin
                state_q <= S_DROP;
              end
            end else if (waitTimingSelect && (master_q || addrMatch_q || extCode_q)) begin
              busInterrupt_q <= 1'b1;
              waitActive_q <= 1'b1;
            end else if (waitTimingSelect && arbLost_q) begin
              busInterrupt_q <= 1'b1;
            end
          end
        end
      end
    end
  end
endmodule // iwa_control
`default_nettype wire

// *** verilog/iwa_map.vh ***
// Constants for the two-wire bus wait, address match and arbitration control
`ifndef IWA_MAP_VH
`define IWA_MAP_VH
`define IWA_ST_MASTER 7
`define IWA_ST_ARBLOST 6
`define IWA_ST_EXTCODE 5
`define IWA_ST_ADDRMATCH 4
`define IWA_ST_TRANSMIT 3
`define IWA_ST_ACKSEEN 2
`define IWA_ST_STARTSEEN 1
`define IWA_ST_STOPSEEN 0
`define IWA_EXT_NONE 3'h0
`define IWA_EXT_GENCALL 3'h1
`define IWA_EXT_STARTBYTE 3'h2
`define IWA_EXT_CBUS 3'h3
`define IWA_EXT_RESERVED 3'h4
`define IWA_EXT_TENBIT 3'h5
`define IWA_CLK8 4'h8
`define IWA_CLK9 4'h9
`define IWA_CNT_PRESTART 4'hf
`define IWA_RESET_STATUS 8'h00
`endif

// *** verilog/iwa_sync.v ***
// Two flip-flop synchroniser for the bus line inputs
`timescale 1ns/10ps
`default_nettype none
module iwa_sync #(
  parameter WIDTH = 2
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Asynchronous levels in, synchronous levels out
  input wire [WIDTH-1:0] asyncIn,
  output reg [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] stage1_q;
  always @(posedge clk) begin
    if (!rst_n) begin
      stage1_q <= {WIDTH{1'b1}};
      syncOut <= {WIDTH{1'b1}};
    end else begin
      stage1_q <= asyncIn;
      syncOut <= stage1_q;
    end
  end
endmodule // iwa_sync
`default_nettype wire

// *** testbench/iwa_control_assertions.sv ***
// Assertion checker for the two-wire wait, match and arbitration control
`timescale 1ns/10ps
`default_nettype none
module iwa_control_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pin enables
  input wire logic sclOe,
  input wire logic sdaOe,
  // Controls
  input wire logic stopInterruptEnable,
  input wire logic waitRelease,
  input wire logic shiftWrite,
  input wire logic startRequest,
  input wire logic stopRequest,
  // Status
  input wire logic [7:0] busStatusRegister,
  input wire logic [2:0] extensionKind_q,
  input wire logic busInterrupt_q,
  input wire logic waitActive_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_wait_holds_scl: assert property (waitActive_q |-> sclOe) else $error("Clock free in wait");
  a_release_ends_wait: assert property (waitActive_q && (waitRelease || shiftWrite || startRequest || stopRequest)
    |=> !waitActive_q) else $error("Wait kept after release");
  a_wait_with_irq: assert property ($rose(waitActive_q) |-> busInterrupt_q) else $error("Wait without irq");
  a_irq_single: assert property (busInterrupt_q |=> !busInterrupt_q) else $error("Irq longer than one cycle");
  a_stop_irq_on: assert property ($rose(busStatusRegister[0]) && stopInterruptEnable
    |-> ##[0:2] busInterrupt_q) else $error("No irq on stop");
  a_stop_irq_off: assert property ($rose(busStatusRegister[0]) && !stopInterruptEnable
    |-> !busInterrupt_q [*3]) else $error("Irq on masked stop");
  a_ext_has_kind: assert property ($rose(busStatusRegister[5])
    |-> ##[0:1] extensionKind_q != 3'h0) else $error("Extension without kind");
  a_match_acks: assert property ($rose(busStatusRegister[4]) && !busStatusRegister[7]
    |-> ##[0:3] sdaOe) else $error("No ack on match");
  a_arb_releases: assert property ($rose(busStatusRegister[6])
    |=> !sdaOe && !sclOe) else $error("Lines held after loss");
  c_wait: cover property ($rose(waitActive_q));
  c_ext: cover property ($rose(busStatusRegister[5]));
  c_stop: cover property ($rose(busStatusRegister[0]) && stopInterruptEnable);
endmodule // iwa_control_assertions
bind iwa_control iwa_control_assertions u_chk (.clk(clk), .rst_n(rst_n), .sclOe(sclOe), .sdaOe(sdaOe),
  .stopInterruptEnable(stopInterruptEnable), .waitRelease(waitRelease), .shiftWrite(shiftWrite),
  .startRequest(startRequest), .stopRequest(stopRequest), .busStatusRegister(busStatusRegister),
  .extensionKind_q(extensionKind_q), .busInterrupt_q(busInterrupt_q), .waitActive_q(waitActive_q));
`default_nettype wire

// *** testbench/iwa_bus_model.sv ***
// Model of a remote master on the two-wire bus
`timescale 1ns/10ps
`default_nettype none
module iwa_bus_model (
  // Wired line levels
  input wire logic sclLine,
  input wire logic sdaLine,
  // Own drives, high means released
  output logic sclDrv,
  output logic sdaDrv
);
  initial begin
    sclDrv = 1'h1;
    sdaDrv = 1'h1;
  end
  // Start condition
  task start;
    sdaDrv = 1'h0;
    #62.5 sclDrv = 1'h0;
  endtask
  // Byte MSB first, ninth clock samples acknowledge
  task sendByte(input logic [7:0] b, output logic ack);
    logic [8:0] bits;
    bits = {b, 1'h1};
    for (int i = 8; i >= 0; i--) begin
      #31.25 sdaDrv = bits[i];
      #31.25 sclDrv = 1'h1;
      wait (sclLine === 1'h1);
      ack = sdaLine;
      #62.5 sclDrv = 1'h0;
    end
    #50;
  endtask
  // Stop condition, clock then stands high
  task stop;
    #31.25 sdaDrv = 1'h0;
    #31.25 sclDrv = 1'h1;
    wait (sclLine === 1'h1);
    #62.5 sdaDrv = 1'h1;
  endtask
endmodule // iwa_bus_model
`default_nettype wire

// *** testbench/iwa_control_tb.sv ***
// Self-checking bench for the two-wire wait, match and arbitration control
`timescale 1ns/10ps
`default_nettype none
module iwa_control_tb;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic waitTimingSelect = 1'h0;
  logic stopInterruptEnable = 1'h0;
  logic [7:0] localSlaveAddress = 8'ha4;
  logic [2:0] relSel = 3'h1;
  logic [2:0] relPulse = 3'h0;
  logic startReq = 1'h0;
  logic swReq = 1'h0;
  logic [7:0] shiftData, irqData;
  logic sclDrv, sdaDrv, sclOe, sdaOe, busInterrupt_q, waitActive_q, ackA, ackD;
  logic [7:0] busStatusRegister;
  logic [2:0] extensionKind_q;
  int falls, irqAt, irqN, nMismatch, samplesChecked;
  wire sclLine = sclDrv & ~sclOe;
  wire sdaLine = sdaDrv & ~sdaOe;
  always #5 clk = ~clk;
  iwa_control u_dut (.clk(clk), .rst_n(rst_n), .sclIn(sclLine), .sclOut(), .sclOe(sclOe), .sdaIn(sdaLine),
    .sdaOut(), .sdaOe(sdaOe), .waitTimingSelect(waitTimingSelect), .acknowledgeEnable(1'h0),
    .stopInterruptEnable(stopInterruptEnable), .localSlaveAddress(localSlaveAddress), .waitRelease(relPulse[0]),
    .startRequest(startReq), .stopRequest(1'h0), .leaveCommunication(relPulse[2]), .arbLostClear(1'h0),
    .shiftWrite(relPulse[1] | swReq), .shiftWriteData(8'hff), .shiftData_q(shiftData),
    .busStatusRegister(busStatusRegister),
    .extensionKind_q(extensionKind_q), .busInterrupt_q(busInterrupt_q), .waitActive_q(waitActive_q));
  iwa_bus_model u_bus (.sclLine(sclLine), .sdaLine(sdaLine), .sclDrv(sclDrv), .sdaDrv(sdaDrv));
  // Clock fall count per frame and interrupt log
  always @(negedge sclLine) falls++;
  always @(negedge sdaLine) if (sclLine === 1'h1) begin
    // Own fall of the start is no bit
    falls = -1;
    irqAt = 0;
  end
  always @(posedge clk) if (busInterrupt_q === 1'h1) begin
    irqAt = falls;
    irqData = shiftData;
    irqN++;
  end
  // Software answer to each wait
  always @(posedge clk) begin
    #1 relPulse = (waitActive_q === 1'h1 && relPulse === 3'h0) ? relSel : 3'h0;
  end
  task automatic chk(input logic ok, input string msg);
    samplesChecked++;
    if (ok !== 1'h1) begin
      nMismatch++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  task automatic setCtl(input logic wts, input logic sie, input logic [2:0] rel);
    @(posedge clk);
    #1 waitTimingSelect = wts;
    stopInterruptEnable = sie;
    relSel = rel;
  endtask
  task automatic endFrame;
    u_bus.stop();
    repeat (20) @(posedge clk);
  endtask
  // Matched address, data wait at eight or nine
  task automatic t_match_wait;
    for (int w = 0; w < 2; w++) begin
      setCtl(w[0], 1'h0, w ? 3'h2 : 3'h1);
      u_bus.start();
      u_bus.sendByte(8'ha4, ackA);
      chk(irqAt == 9 && ackA === 1'h0, "match irq or ack");
      chk(irqData === 8'ha4, "address shifted in");
      u_bus.sendByte(8'h5a, ackD);
      chk(irqAt == (w ? 18 : 17), "data wait clock");
      chk(irqData === 8'h5a, "data shifted in");
      endFrame();
    end
  endtask
  // Foreign address, stop interrupt gating
  task automatic t_stop_gate;
    int n;
    for (int s = 0; s < 2; s++) begin
      setCtl(1'h1, s[0], 3'h1);
      u_bus.start();
      u_bus.sendByte(8'h52, ackA);
      chk(irqAt == 0 && ackA === 1'h1, "foreign address");
      n = irqN;
      endFrame();
      chk(irqN == n + s, "stop irq gating");
    end
  endtask
  // Extension codes, ten-bit match, leave
  task automatic t_ext;
    logic [7:0] code [5] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'hf0};
    int n;
    for (int k = 0; k < 6; k++) begin
      setCtl(1'h0, 1'h0, 3'h1);
      localSlaveAddress = (k == 5) ? 8'hf2 : 8'ha4;
      u_bus.start();
      u_bus.sendByte((k == 5) ? 8'hf2 : code[k], ackA);
      chk(irqAt == 8 && busStatusRegister[5] === 1'h1, "extension flag");
      chk(k == 5 ? busStatusRegister[4] === 1'h1 : extensionKind_q === 3'(k + 1), "kind or match");
      endFrame();
    end
    setCtl(1'h0, 1'h0, 3'h4);
    u_bus.start();
    u_bus.sendByte(8'h00, ackA);
    n = irqN;
    u_bus.sendByte(8'h3c, ackD);
    chk(ackA === 1'h1 && irqN == n, "leave");
    endFrame();
  endtask
  // Own start, arbitration lost on first address bit
  task automatic t_arb;
    int n;
    setCtl(1'h1, 1'h1, 3'h1);
    startReq = 1'h1;
    @(posedge clk);
    #1 startReq = 1'h0;
    repeat (5) @(posedge clk);
    #1;
    chk(busStatusRegister[7] === 1'h1 && busStatusRegister[1] === 1'h1, "own start");
    u_bus.start();
    @(posedge clk);
    #1 swReq = 1'h1;
    @(posedge clk);
    #1 swReq = 1'h0;
    u_bus.sendByte(8'h52, ackA);
    chk(busStatusRegister[7:6] === 2'h1 && sdaOe === 1'h0 && sclOe === 1'h0, "arbitration loss");
    chk(irqAt == 9 && irqData === 8'h52, "irq or readback after loss");
    n = irqN;
    endFrame();
    chk(irqN == n + 1, "stop irq after loss");
  endtask
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1 rst_n = 1'h1;
    repeat (3) @(posedge clk);
    t_match_wait();
    t_stop_gate();
    t_ext();
    t_arb();
    conclude();
  end
  initial begin
    #200_000;
    nMismatch++;
    conclude();
  end
endmodule // iwa_control_tb
`default_nettype wire
